//--- logic/uvlo_seq_params.svh
// Constants for the UVLO and overcurrent fault sequencer
`ifndef UVLO_SEQ_PARAMS_SVH
`define UVLO_SEQ_PARAMS_SVH
`define CNT_W 3
`define CNT_MAX 3'h7
`define CNT_ZERO 3'h0
`define RESTART_SS_CYCLES 3'h7
`define SS_CYCLE_CLKS 8'hFF
`endif

//--- logic/uvlo_seq_pkg.sv
// Types for the UVLO and overcurrent fault sequencer
package uvlo_seq_pkg;
  typedef enum logic [1:0] {
    ST_LOCKOUT = 2'h0,
    ST_RUN = 2'h1,
    ST_RESTART = 2'h3
  } seq_state_t;
endpackage : uvlo_seq_pkg

//--- logic/uvlo_fault_seq.sv
// UVLO filter and two-tier overcurrent fault sequencer
`timescale 1ns/1ps
`include "uvlo_seq_params.svh"
// Operation
// - Clock pulse before ramp reaches 90 percent marks a low-line cycle.
// - Per-cycle comparison is filtered by a 3-bit up/down counter.
// - Seven good cycles assert power-good, start soft-start, gates off.
// - After start, seven low-line cycles needed to declare undervoltage.
// - Soft-start held low until both rails good and low-line check good.
// - PWM never starts while the ramp misses the clock period.
// - Overcurrent trip ends the high-side pulse until next cycle.
// - Fault count up on cycles with overcurrent, down on cycles without.
// - Count of seven issues restart of seven soft-start cycles, gates off.
// - Restart decrements count per soft-start cycle; zero re-enables PWM.
// - Persistent overload accumulates seven pulses and restarts again.
// - Sync pulse interrupting the ramp counts as an undervoltage cycle.
module uvlo_fault_seq (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic osc_clk_i,
  input wire logic sync_i,
  input wire logic ramp_done_i,
  input wire logic overcurrent_i,
  input wire logic low_bypass_rail_good_i,
  input wire logic high_bypass_rail_good_i,
  output logic pwm_en_o,
  output logic power_good_o,
  output logic ss_hold_o,
  output logic ss_restart_o,
  output logic hs_gate_o,
  output logic ls_gate_o,
  output logic uv_fault_o
);

  // Pin synchronisers
  logic [5:0] s1_ff;
  logic [5:0] s2_ff;
  logic [5:0] pins;
  assign pins = {osc_clk_i, sync_i, ramp_done_i, overcurrent_i,
                 low_bypass_rail_good_i, high_bypass_rail_good_i};
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      s1_ff <= 6'h00;
      s2_ff <= 6'h00;
    end
    else
    begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
    end
  end
  logic osc_s, sync_s, ramp_s, oc_s, rails_ok;
  assign osc_s = s2_ff[5];
  assign sync_s = s2_ff[4];
  assign ramp_s = s2_ff[3];
  assign oc_s = s2_ff[2];
  assign rails_ok = s2_ff[1] & s2_ff[0];

  function automatic logic [`CNT_W-1:0] sat_step(input logic [`CNT_W-1:0] v,
                                                   input logic up);
    logic [`CNT_W-1:0] r;
    r = v;
    if (up && v != `CNT_MAX)
      r = v + 3'h1;
    else if (!up && v != `CNT_ZERO)
      r = v - 3'h1;
    return r;
  endfunction : sat_step

  logic osc_d_ff, sync_d_ff, ramp_seen_ff, oc_seen_ff, hs_block_ff;
  logic [`CNT_W-1:0] uv_cnt_ff, flt_cnt_ff;
  logic [2:0] ss_left_ff;
  logic [7:0] ss_tmr_ff;
  uvlo_seq_pkg::seq_state_t st_ff;
  logic line_ok_ff, cut_ff;
  logic pwm_en_ff, pg_ff, ss_hold_ff, ss_rst_ff, hs_ff, ls_ff, uv_ff;

  logic nxt_osc_d, nxt_sync_d, nxt_ramp_seen, nxt_oc_seen, nxt_hs_block;
  logic [`CNT_W-1:0] nxt_uv_cnt, nxt_flt_cnt;
  logic [2:0] nxt_ss_left;
  logic [7:0] nxt_ss_tmr;
  uvlo_seq_pkg::seq_state_t nxt_st;
  logic nxt_line_ok, nxt_cut;
  logic nxt_pwm_en, nxt_pg, nxt_ss_hold, nxt_ss_rst, nxt_hs, nxt_ls, nxt_uv;
  logic cyc_start, sync_edge, low_line, run_now;

  always_comb
  begin
    cyc_start = osc_s & ~osc_d_ff;
    sync_edge = sync_s & ~sync_d_ff;
    nxt_osc_d = osc_s;
    nxt_sync_d = sync_s;
    nxt_cut = cyc_start ? 1'b0 : (cut_ff | (sync_edge & ~(ramp_seen_ff | ramp_s)));
    low_line = cyc_start & (cut_ff | ~(ramp_seen_ff | ramp_s));
    nxt_ramp_seen = cyc_start ? 1'b0 : (ramp_seen_ff | ramp_s);
    nxt_oc_seen = cyc_start ? 1'b0 : (oc_seen_ff | oc_s);
    nxt_uv_cnt = uv_cnt_ff;
    nxt_line_ok = line_ok_ff;
    if (cyc_start)
      nxt_uv_cnt = sat_step(uv_cnt_ff, ~low_line);
    if (!line_ok_ff && nxt_uv_cnt == `CNT_MAX)
      nxt_line_ok = 1'b1;
    else if (line_ok_ff && nxt_uv_cnt == `CNT_ZERO)
      nxt_line_ok = 1'b0;
    nxt_st = st_ff;
    nxt_flt_cnt = flt_cnt_ff;
    nxt_ss_left = ss_left_ff;
    nxt_ss_tmr = ss_tmr_ff;
    nxt_hs_block = hs_block_ff;
    case (st_ff)
      uvlo_seq_pkg::ST_LOCKOUT:
      begin
        nxt_flt_cnt = `CNT_ZERO;
        if (rails_ok && nxt_line_ok)
          nxt_st = uvlo_seq_pkg::ST_RUN;
      end
      uvlo_seq_pkg::ST_RUN:
      begin
        if (oc_s)
          nxt_hs_block = 1'b1;
        if (cyc_start)
          nxt_hs_block = oc_s;
        if (cyc_start)
          nxt_flt_cnt = sat_step(flt_cnt_ff, oc_seen_ff | oc_s);
        if (!rails_ok || !nxt_line_ok)
          nxt_st = uvlo_seq_pkg::ST_LOCKOUT;
        else if (nxt_flt_cnt == `CNT_MAX)
        begin
          nxt_st = uvlo_seq_pkg::ST_RESTART;
          nxt_ss_left = `RESTART_SS_CYCLES;
          nxt_ss_tmr = `SS_CYCLE_CLKS;
        end
      end
      uvlo_seq_pkg::ST_RESTART:
      begin
        nxt_hs_block = 1'b1;
        if (ss_tmr_ff == 8'h00)
        begin
          nxt_ss_tmr = `SS_CYCLE_CLKS;
          nxt_flt_cnt = sat_step(flt_cnt_ff, 1'b0);
          nxt_ss_left = ss_left_ff - 3'h1;
        end
        else
          nxt_ss_tmr = ss_tmr_ff - 8'h01;
        if (nxt_flt_cnt == `CNT_ZERO)
        begin
          nxt_st = uvlo_seq_pkg::ST_RUN;
          nxt_hs_block = 1'b0;
        end
        if (!rails_ok || !nxt_line_ok)
          nxt_st = uvlo_seq_pkg::ST_LOCKOUT;
      end
      default:
        nxt_st = uvlo_seq_pkg::ST_LOCKOUT;
    endcase
    nxt_pwm_en = (nxt_st == uvlo_seq_pkg::ST_RUN);
    nxt_pg = nxt_line_ok & rails_ok;
    nxt_ss_hold = (nxt_st == uvlo_seq_pkg::ST_LOCKOUT);
    nxt_ss_rst = (nxt_st == uvlo_seq_pkg::ST_RESTART);
    run_now = nxt_pwm_en & (st_ff == uvlo_seq_pkg::ST_RUN);
    nxt_hs = run_now & ~nxt_hs_block & ~oc_s & ~cyc_start;
    nxt_ls = run_now & ~nxt_hs;
    nxt_uv = ~nxt_line_ok;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      osc_d_ff <= 1'b0;
      sync_d_ff <= 1'b0;
      ramp_seen_ff <= 1'b0;
      oc_seen_ff <= 1'b0;
      hs_block_ff <= 1'b0;
      uv_cnt_ff <= `CNT_ZERO;
      flt_cnt_ff <= `CNT_ZERO;
      ss_left_ff <= 3'h0;
      ss_tmr_ff <= 8'h00;
      st_ff <= uvlo_seq_pkg::ST_LOCKOUT;
      line_ok_ff <= 1'b0;
      cut_ff <= 1'b0;
      pwm_en_ff <= 1'b0;
      pg_ff <= 1'b0;
      ss_hold_ff <= 1'b1;
      ss_rst_ff <= 1'b0;
      hs_ff <= 1'b0;
      ls_ff <= 1'b0;
      uv_ff <= 1'b1;
    end
    else
    begin
      osc_d_ff <= nxt_osc_d;
      sync_d_ff <= nxt_sync_d;
      ramp_seen_ff <= nxt_ramp_seen;
      oc_seen_ff <= nxt_oc_seen;
      hs_block_ff <= nxt_hs_block;
      uv_cnt_ff <= nxt_uv_cnt;
      flt_cnt_ff <= nxt_flt_cnt;
      ss_left_ff <= nxt_ss_left;
      ss_tmr_ff <= nxt_ss_tmr;
      st_ff <= nxt_st;
      line_ok_ff <= nxt_line_ok;
      cut_ff <= nxt_cut;
      pwm_en_ff <= nxt_pwm_en;
      pg_ff <= nxt_pg;
      ss_hold_ff <= nxt_ss_hold;
      ss_rst_ff <= nxt_ss_rst;
      hs_ff <= nxt_hs;
      ls_ff <= nxt_ls;
      uv_ff <= nxt_uv;
    end
  end

  assign pwm_en_o = pwm_en_ff;
  assign power_good_o = pg_ff;
  assign ss_hold_o = ss_hold_ff;
  assign ss_restart_o = ss_rst_ff;
  assign hs_gate_o = hs_ff;
  assign ls_gate_o = ls_ff;
  assign uv_fault_o = uv_ff;

  property p_cnt_sat;
    @(posedge mclk_i) disable iff (!nrst_i)
    (uv_cnt_ff == `CNT_MAX && !low_line) |=> uv_cnt_ff == `CNT_MAX;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("uv count wrapped");
  property p_low_line;
    @(posedge mclk_i) disable iff (!nrst_i)
    (low_line && uv_cnt_ff != `CNT_ZERO) |=> uv_cnt_ff == $past(uv_cnt_ff) - 3'h1;
  endproperty
  a_low_line: assert property (p_low_line) else $error("low-line not counted");
  property p_hold;
    @(posedge mclk_i) disable iff (!nrst_i)
    !rails_ok |=> ss_hold_o && !pwm_en_o;
  endproperty
  a_hold: assert property (p_hold) else $error("soft-start not held");
  property p_oc_cut;
    @(posedge mclk_i) disable iff (!nrst_i)
    oc_s |=> !hs_gate_o;
  endproperty
  a_oc_cut: assert property (p_oc_cut) else $error("high side not cut");
  property p_restart_off;
    @(posedge mclk_i) disable iff (!nrst_i)
    ss_restart_o |-> !hs_gate_o && !ls_gate_o && !pwm_en_o;
  endproperty
  a_restart_off: assert property (p_restart_off) else $error("gates on in restart");
  property p_no_start;
    @(posedge mclk_i) disable iff (!nrst_i)
    !line_ok_ff |-> !pwm_en_o && !hs_gate_o && !ls_gate_o;
  endproperty
  a_no_start: assert property (p_no_start) else $error("pwm ran on low line");
  property p_flt_sat;
    @(posedge mclk_i) disable iff (!nrst_i)
    st_ff == uvlo_seq_pkg::ST_RESTART
      |-> flt_cnt_ff == ss_left_ff && flt_cnt_ff != `CNT_ZERO;
  endproperty
  a_flt_sat: assert property (p_flt_sat) else $error("fault count bad");
  property p_uv_decl;
    @(posedge mclk_i) disable iff (!nrst_i)
    $fell(line_ok_ff) |-> uv_cnt_ff == `CNT_ZERO;
  endproperty
  a_uv_decl: assert property (p_uv_decl) else $error("early undervoltage");
  sequence s_ss_period_end;
    st_ff == uvlo_seq_pkg::ST_RESTART && ss_tmr_ff == 8'h00;
  endsequence
  property p_ss_step;
    @(posedge mclk_i) disable iff (!nrst_i)
    s_ss_period_end |=> flt_cnt_ff == $past(flt_cnt_ff) - 3'h1;
  endproperty
  a_ss_step: assert property (p_ss_step) else $error("restart count not stepped");
  sequence s_restart_entry;
    st_ff == uvlo_seq_pkg::ST_RUN && nxt_st == uvlo_seq_pkg::ST_RESTART;
  endsequence
  property p_restart_load;
    @(posedge mclk_i) disable iff (!nrst_i)
    s_restart_entry |=> ss_restart_o && ss_left_ff == `RESTART_SS_CYCLES
      && ss_tmr_ff == `SS_CYCLE_CLKS;
  endproperty
  a_restart_load: assert property (p_restart_load) else $error("restart not loaded");
  property p_fault_up;
    @(posedge mclk_i) disable iff (!nrst_i)
    (st_ff == uvlo_seq_pkg::ST_RUN && cyc_start && (oc_seen_ff || oc_s)
      && flt_cnt_ff != `CNT_MAX) |=> flt_cnt_ff == $past(flt_cnt_ff) + 3'h1;
  endproperty
  a_fault_up: assert property (p_fault_up) else $error("fault pulse not counted");
  property p_start_gates;
    @(posedge mclk_i) disable iff (!nrst_i)
    $rose(power_good_o) |-> !hs_gate_o && !ls_gate_o;
  endproperty
  a_start_gates: assert property (p_start_gates) else $error("gates on at power-good");
  property p_cut_counts;
    @(posedge mclk_i) disable iff (!nrst_i)
    (cut_ff && cyc_start && uv_cnt_ff != `CNT_ZERO) |=> uv_cnt_ff == $past(uv_cnt_ff) - 3'h1;
  endproperty
  a_cut_counts: assert property (p_cut_counts) else $error("cut cycle not counted");

endmodule : uvlo_fault_seq

//--- verification/power_stage_model.sv
// Oscillator, ramp comparator and switch current sense model
`timescale 1ns/1ps
module power_stage_model (
  input wire logic mclk_i,
  input wire logic slow_ramp_i,
  input wire logic sync_cut_i,
  input wire logic overload_i,
  input wire logic hs_gate_i,
  output logic osc_clk_o,
  output logic sync_o,
  output logic ramp_done_o,
  output logic overcurrent_o
);
  logic [3:0] phase_ff = 4'h0;
  always @(posedge mclk_i)
  begin
    phase_ff <= phase_ff + 4'h1;
    osc_clk_o <= (phase_ff < 4'h2);
    sync_o <= sync_cut_i && (phase_ff == 4'h3 || phase_ff == 4'h4);
    ramp_done_o <= !slow_ramp_i && (phase_ff == 4'h8 || phase_ff == 4'h9);
    // trips only while high side on
    overcurrent_o <= overload_i && hs_gate_i;
  end
endmodule : power_stage_model

//--- verification/tb_uvlo_fault_seq.sv
// Self-checking bench for the UVLO and fault sequencer
`timescale 1ns/1ps
module tb_uvlo_fault_seq;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic rails = 1'b0;
  logic rails_hi = 1'b0;
  logic slow = 1'b0;
  logic cut = 1'b0;
  logic load = 1'b0;
  logic osc, sync, ramp, oc;
  logic pwm, pg, hold, rst, hs, ls, uv;
  logic [6:0] outs;
  int fails = 0;
  int n_tests = 0;
  localparam int cyc = 16;
  localparam int ssl = 256;
  assign outs = {pwm, pg, hold, rst, hs, ls, uv};
  always #25 mclk_i = ~mclk_i;

  power_stage_model i_model (.mclk_i(mclk_i), .slow_ramp_i(slow), .sync_cut_i(cut),
    .overload_i(load), .hs_gate_i(hs), .osc_clk_o(osc), .sync_o(sync),
    .ramp_done_o(ramp), .overcurrent_o(oc));
  uvlo_fault_seq i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .osc_clk_i(osc), .sync_i(sync),
    .ramp_done_i(ramp), .overcurrent_i(oc), .low_bypass_rail_good_i(rails),
    .high_bypass_rail_good_i(rails_hi), .pwm_en_o(pwm), .power_good_o(pg), .ss_hold_o(hold),
    .ss_restart_o(rst), .hs_gate_o(hs), .ls_gate_o(ls), .uv_fault_o(uv));

  task automatic complete_run();
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait for an output bit to reach a level
  task automatic wait_bit(input int b, input logic v, input int lim);
    for (int i = 0; i < lim && outs[b] !== v; i++)
      @(negedge mclk_i);
    chk(outs[b], v);
    if (outs[b] !== v)
      complete_run();
  endtask : wait_bit

  // Output bit must keep a level for n cycles
  task automatic hold_bit(input int b, input logic v, input int n);
    for (int i = 0; i < n && outs[b] === v; i++)
      @(negedge mclk_i);
    chk(outs[b], v);
  endtask : hold_bit

  task automatic t_rails();
    hold_bit(4, 1'b1, 12 * cyc);
    chk(pwm, 1'b0);
    @(posedge mclk_i) rails <= 1'b1;
    hold_bit(4, 1'b1, cyc);
    @(posedge mclk_i) rails_hi <= 1'b1;
    wait_bit(5, 1'b1, 3 * cyc);
    chk(hs | ls, 1'b0);
    wait_bit(4, 1'b0, 3 * cyc);
    wait_bit(6, 1'b1, 3 * cyc);
  endtask : t_rails

  task automatic t_lowline();
    @(posedge mclk_i) slow <= 1'b1;
    repeat (cyc) @(posedge mclk_i);
    slow <= 1'b0;
    hold_bit(0, 1'b0, 10 * cyc);
    @(posedge mclk_i) slow <= 1'b1;
    hold_bit(0, 1'b0, 5 * cyc);
    wait_bit(0, 1'b1, 4 * cyc);
    chk(pwm, 1'b0);
    repeat (4 * cyc) @(posedge mclk_i);
    slow <= 1'b0;
    hold_bit(5, 1'b0, 6 * cyc);
    wait_bit(5, 1'b1, 4 * cyc);
    wait_bit(6, 1'b1, 3 * cyc);
  endtask : t_lowline

  task automatic t_sync();
    @(posedge mclk_i) cut <= 1'b1;
    wait_bit(0, 1'b1, 10 * cyc);
    chk(pwm, 1'b0);
    @(posedge mclk_i) cut <= 1'b0;
    wait_bit(6, 1'b1, 12 * cyc);
  endtask : t_sync

  task automatic t_fault();
    @(posedge mclk_i) load <= 1'b1;
    for (int i = 0; i < 4 * cyc && oc !== 1'b1; i++)
      @(negedge mclk_i);
    chk(oc, 1'b1);
    if (oc !== 1'b1)
      complete_run();
    repeat (5) @(negedge mclk_i);
    chk(hs, 1'b0);
    hold_bit(3, 1'b0, 4 * cyc);
    wait_bit(3, 1'b1, 6 * cyc);
    chk(pwm, 1'b0);
    @(posedge mclk_i) load <= 1'b0;
    hold_bit(2, 1'b0, 3 * ssl);
    hold_bit(1, 1'b0, 3 * ssl);
    wait_bit(6, 1'b1, 2 * ssl);
    chk(rst, 1'b0);
    @(posedge mclk_i) load <= 1'b1;
    wait_bit(3, 1'b1, 10 * cyc);
    @(posedge mclk_i) load <= 1'b0;
    wait_bit(6, 1'b1, 8 * ssl);
  endtask : t_fault

  initial
  begin
    repeat (8) @(posedge mclk_i);
    chk(hold, 1'b1);
    chk(pwm, 1'b0);
    nrst_i <= 1'b1;
    t_rails();
    t_lowline();
    t_sync();
    t_fault();
    complete_run();
  end
endmodule : tb_uvlo_fault_seq
